// [asc_ctrl.sv]
// Host controller for an asynchronous 1M x 16 static memory.
// Assumes the memory pins are wired straight to the outputs; data bus is split in/out/enable.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Write needs selects active and strobe low
// - Read needs selects, output enable, strobe high
// - Write period is overlap of strobes
// - Host drives no data while memory drives
// - Address valid before selects assert (here address and selects latch on the same edge)
// - Address stable across the whole write
// - Write data set up before write end
// - Address steady from write start to end
// - Data may drop when write ends
module asc_ctrl import asc_pkg::*; (
  input wire logic SYS_CLK_IN,
  input wire logic RESET_IN,
  input wire logic REQ_VALID_IN,
  input wire logic REQ_WRITE_IN,
  input wire logic [ADDR_W-1:0] REQ_ADDR_IN,
  input wire logic [DATA_W-1:0] REQ_WDATA_IN,
  input wire logic [1:0] REQ_BYTE_EN_IN,
  output logic REQ_READY_OUT,
  output logic RSP_VALID_OUT,
  output logic [DATA_W-1:0] RSP_RDATA_OUT,
  output logic [ADDR_W-1:0] MEM_ADDR_OUT,
  output logic MEM_CHIP_SELECT_N_OUT,
  output logic MEM_CHIP_SELECT_HI_OUT,
  output logic MEM_WRITE_STROBE_N_OUT,
  output logic MEM_OUTPUT_EN_N_OUT,
  output logic MEM_HIGH_BYTE_SEL_N_OUT,
  output logic MEM_LOW_BYTE_SEL_N_OUT,
  input wire logic [DATA_W-1:0] MEM_DATA_IN,
  output logic [DATA_W-1:0] MEM_DATA_OUT,
  output logic MEM_DATA_OE_N_OUT
);
  asc_state_t state_r, state_nxt;
  logic [DATA_W-1:0] din_s1_r, din_s2_r, din_s3_r;
  logic [DATA_W-1:0] rdata_r;
  logic rsp_valid_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [1:0] ben_n_r;
  logic cs_n_r, cs_hi_r, we_n_r, oe_n_r, doe_n_r;
  logic tmr_load, tmr_done;
  logic [3:0] tmr_count;
  logic take_req, take_rd, take_wr, rd_done, wr_start, wr_done;

  // Data pins pass three flops; the last one is captured on rd_done
  always_ff @(posedge SYS_CLK_IN) begin
    din_s1_r <= MEM_DATA_IN;
    din_s2_r <= din_s1_r;
    din_s3_r <= din_s2_r;
  end

  assign take_req = (state_r == ASC_IDLE) && REQ_VALID_IN && (REQ_BYTE_EN_IN != 2'h0);
  assign take_rd = take_req && !REQ_WRITE_IN;
  assign take_wr = take_req && REQ_WRITE_IN;
  // Extra cycles let the sampling pipeline catch up
  assign rd_done = (state_r == ASC_RD) && tmr_done;
  assign wr_start = (state_r == ASC_WTURN) && tmr_done;
  assign wr_done = (state_r == ASC_WR) && tmr_done;
  assign tmr_load = take_rd || take_wr || wr_start || wr_done;
  assign tmr_count = take_rd ? 4'(RD_CYC + 3) : (take_wr ? 4'(TURN_CYC) : (wr_start ? 4'(WR_CYC) : 4'h1));

  asc_timer #(.CNT_W(4)) u_timer (
    .SYS_CLK_IN(SYS_CLK_IN),
    .RESET_IN(RESET_IN),
    .load_in(tmr_load),
    .count_in(tmr_count),
    .done_out(tmr_done)
  );

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ASC_IDLE: begin
        if (take_rd) state_nxt = ASC_RD;
        else if (take_wr) state_nxt = ASC_WTURN;
      end
      ASC_RD: if (rd_done) state_nxt = ASC_RECOV;
      ASC_WTURN: if (wr_start) state_nxt = ASC_WR;
      ASC_WR: if (wr_done) state_nxt = ASC_RECOV;
      ASC_RECOV: if (tmr_done || !tmr_load) state_nxt = ASC_IDLE;
      default: state_nxt = ASC_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) state_r <= ASC_IDLE;
    else state_r <= state_nxt;
  end

  // Address, selects and data latched together so address leads nothing
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      addr_r <= ADDR_RESET;
      wdata_r <= DATA_RESET;
      ben_n_r <= 2'h3;
      cs_n_r <= 1'b1;
      cs_hi_r <= 1'b0;
    end else if (take_req) begin
      addr_r <= REQ_ADDR_IN;
      wdata_r <= REQ_WDATA_IN;
      ben_n_r <= ~REQ_BYTE_EN_IN;
      cs_n_r <= 1'b0;
      cs_hi_r <= 1'b1;
    end else if (rd_done || wr_done) begin
      ben_n_r <= 2'h3;
      cs_n_r <= 1'b1;
      cs_hi_r <= 1'b0;
    end
  end

  // Strobes: read enable over RD, write strobe only after turnaround
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      we_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      doe_n_r <= 1'b1;
    end else begin
      oe_n_r <= !(take_rd || ((state_r == ASC_RD) && !rd_done));
      we_n_r <= !(wr_start || ((state_r == ASC_WR) && !wr_done));
      doe_n_r <= !(take_wr || (state_r == ASC_WTURN) ||
                   ((state_r == ASC_WR) && !wr_done));
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      rdata_r <= DATA_RESET;
      rsp_valid_r <= 1'b0;
    end else begin
      rsp_valid_r <= rd_done;
      if (rd_done) rdata_r <= din_s3_r;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) REQ_READY_OUT <= 1'b0;
    else REQ_READY_OUT <= (state_nxt == ASC_IDLE);
  end

  assign RSP_VALID_OUT = rsp_valid_r;
  assign RSP_RDATA_OUT = rdata_r;
  assign MEM_ADDR_OUT = addr_r;
  assign MEM_CHIP_SELECT_N_OUT = cs_n_r;
  assign MEM_CHIP_SELECT_HI_OUT = cs_hi_r;
  assign MEM_WRITE_STROBE_N_OUT = we_n_r;
  assign MEM_OUTPUT_EN_N_OUT = oe_n_r;
  assign MEM_HIGH_BYTE_SEL_N_OUT = ben_n_r[1];
  assign MEM_LOW_BYTE_SEL_N_OUT = ben_n_r[0];
  assign MEM_DATA_OUT = wdata_r;
  assign MEM_DATA_OE_N_OUT = doe_n_r;

  property p_no_contention;
    @(posedge SYS_CLK_IN) disable iff (RESET_IN) !(!doe_n_r && !oe_n_r);
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("Bus driven during read");

  property p_we_needs_sel;
    @(posedge SYS_CLK_IN) disable iff (RESET_IN) !we_n_r |-> (!cs_n_r && cs_hi_r && ben_n_r != 2'h3);
  endproperty
  a_we_needs_sel: assert property (p_we_needs_sel) else $error("Write strobe without select");

  property p_we_oe_excl;
    @(posedge SYS_CLK_IN) disable iff (RESET_IN) !oe_n_r |-> we_n_r;
  endproperty
  a_we_oe_excl: assert property (p_we_oe_excl) else $error("Read with write strobe low");

  property p_data_before_we;
    @(posedge SYS_CLK_IN) disable iff (RESET_IN) $fell(we_n_r) |-> $past(!doe_n_r);
  endproperty
  a_data_before_we: assert property (p_data_before_we) else $error("Write data late");

  property p_addr_stable_wr;
    @(posedge SYS_CLK_IN) disable iff (RESET_IN) !we_n_r |-> $stable(addr_r);
  endproperty
  a_addr_stable_wr: assert property (p_addr_stable_wr) else $error("Address moved in write");

  property p_we_width;
    @(posedge SYS_CLK_IN) disable iff (RESET_IN) $fell(we_n_r) |-> !we_n_r [*2];
  endproperty
  a_we_width: assert property (p_we_width) else $error("Write strobe too short");

  property p_rd_len;
    @(posedge SYS_CLK_IN) disable iff (RESET_IN) $fell(oe_n_r) |-> !oe_n_r [*5] ##1 oe_n_r;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("Read length wrong");

  property p_rsp_after_rd;
    @(posedge SYS_CLK_IN) disable iff (RESET_IN) $rose(oe_n_r) |-> rsp_valid_r;
  endproperty
  a_rsp_after_rd: assert property (p_rsp_after_rd) else $error("No response after read");

  property p_data_during_we;
    @(posedge SYS_CLK_IN) disable iff (RESET_IN) !we_n_r |-> !doe_n_r;
  endproperty
  a_data_during_we: assert property (p_data_during_we) else $error("Write data not driven");

  property p_release_after_done;
    @(posedge SYS_CLK_IN) disable iff (RESET_IN) (rd_done || wr_done) |=> (cs_n_r && !cs_hi_r && we_n_r && oe_n_r && doe_n_r);
  endproperty
  a_release_after_done: assert property (p_release_after_done) else $error("Pins not released");

  property p_addr_stable_sel;
    @(posedge SYS_CLK_IN) disable iff (RESET_IN) (!cs_n_r && $past(!cs_n_r)) |-> $stable(addr_r);
  endproperty
  a_addr_stable_sel: assert property (p_addr_stable_sel) else $error("Address moved while selected");
endmodule
`default_nettype wire

// [asc_pkg.sv]
// Package for the asynchronous static memory controller.
// Assumes a single 20 MHz system clock; all timing derived from it.
package asc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 16;
  // Slow grade figures, the safe choice for either grade
  localparam int unsigned T_RC_NS = 70;
  localparam int unsigned T_AA_NS = 70;
  localparam int unsigned T_DOE_NS = 35;
  localparam int unsigned T_WC_NS = 70;
  localparam int unsigned T_AW_NS = 60;
  localparam int unsigned T_SD_NS = 30;
  localparam int unsigned T_HZWE_NS = 25;
  // Least times round up to whole cycles, at least one
  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int unsigned RD_CYC = ns_to_cyc(T_AA_NS);
  localparam int unsigned WR_CYC = ns_to_cyc(T_AW_NS);
  localparam int unsigned TURN_CYC = ns_to_cyc(T_HZWE_NS);
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 20'h00000;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  typedef enum logic [2:0] {
    ASC_IDLE = 3'b000,
    ASC_RD = 3'b001,
    ASC_WTURN = 3'b011,
    ASC_WR = 3'b010,
    ASC_RECOV = 3'b110
  } asc_state_t;
endpackage

// [asc_timer.sv]
// Down counter giving a done pulse after a loaded cycle count.
// Same clock and reset as the controller.
`timescale 1ns/1ps
`default_nettype none
module asc_timer import asc_pkg::*; #(
  parameter int unsigned CNT_W = 4
) (
  input wire logic SYS_CLK_IN,
  input wire logic RESET_IN,
  input wire logic load_in,
  input wire logic [CNT_W-1:0] count_in,
  output logic done_out
);
  logic [CNT_W-1:0] cnt_r;
  logic run_r;
  assign done_out = run_r && (cnt_r == CNT_W'(1));
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      cnt_r <= CNT_W'(CNT_RESET);
      run_r <= 1'b0;
    end else if (load_in) begin
      cnt_r <= count_in;
      run_r <= 1'b1;
    end else if (run_r) begin
      cnt_r <= cnt_r - CNT_W'(1);
      run_r <= (cnt_r != CNT_W'(1));
    end
  end
endmodule
`default_nettype wire

// [asc_sram_model.sv]
// Behavioural 1M x 16 static memory on the far side of the pins.
// Assumes the testbench resolves the shared data bus and feeds it back.
`timescale 1ns/1ps
`default_nettype none
module asc_sram_model import asc_pkg::*; #(
  parameter int unsigned ACC_NS = 70
) (
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic cs_n_in,
  input wire logic cs_hi_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic hb_n_in,
  input wire logic lb_n_in,
  input wire logic [DATA_W-1:0] bus_in,
  input wire logic host_oe_n_in,
  output logic [DATA_W-1:0] rdata_out,
  output logic fault_out
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] word, word_d, pat, wd;
  logic stored_t;
  logic [ADDR_W-1:0] wa;
  logic [1:0] wb, lane_d;
  wire sel = !cs_n_in && cs_hi_in && !(hb_n_in && lb_n_in);
  wire wr = sel && !we_n_in;
  wire rd = sel && we_n_in && !oe_n_in;
  wire [1:0] lane = {rd && !hb_n_in, rd && !lb_n_in};
  initial begin
    pat = 16'h5A5A;
    wb = 2'b00;
    stored_t = 1'b0;
    fault_out = 1'b0;
  end
  // Floating lanes show a changing pattern
  always #25 pat = ~pat;
  // Refresh on address change and after every store
  always @(addr_in or stored_t) word = mem[addr_in];
  assign #(ACC_NS) word_d = word;
  assign #(ACC_NS) lane_d = lane;
  assign rdata_out = {lane[1] && lane_d[1] ? word_d[15:8] : pat[15:8],
                      lane[0] && lane_d[0] ? word_d[7:0] : pat[7:0]};
  always @* if (wr && !host_oe_n_in) begin
    wa = addr_in;
    wd = bus_in;
    wb = {!hb_n_in, !lb_n_in};
  end
  // Store at the end of the overlap
  always @(negedge wr) if (wb != 2'b00) begin
    if (wb[1]) mem[wa][15:8] = wd[15:8];
    if (wb[0]) mem[wa][7:0] = wd[7:0];
    wb = 2'b00;
    stored_t = !stored_t;
  end
  always @(addr_in) if (wr) fault_out = 1'b1;
  always @* if (rd && !host_oe_n_in) fault_out = 1'b1;
endmodule
`default_nettype wire

// [tb_async_sram_1m_x16.sv]
// Self-checking testbench for the static memory controller.
// Assumes the memory model on the pins; bus resolved here.
`timescale 1ns/1ps
`default_nettype none
module tb_async_sram_1m_x16 import asc_pkg::*; ;
  logic clk, rst, rv, rw, rdy, rsv, cs_n, cs_hi, we_n, oe_n, hb_n, lb_n, doe_n, flt;
  logic [19:0] ra, ma;
  logic [15:0] rd_d, rsd, din, dout, mq;
  logic [1:0] rbe;
  int n_errors = 0;
  int comparisons = 0;
  assign din = doe_n ? mq : dout;
  asc_ctrl uut (.SYS_CLK_IN(clk), .RESET_IN(rst), .REQ_VALID_IN(rv), .REQ_WRITE_IN(rw),
    .REQ_ADDR_IN(ra), .REQ_WDATA_IN(rd_d), .REQ_BYTE_EN_IN(rbe), .REQ_READY_OUT(rdy),
    .RSP_VALID_OUT(rsv), .RSP_RDATA_OUT(rsd), .MEM_ADDR_OUT(ma), .MEM_CHIP_SELECT_N_OUT(cs_n),
    .MEM_CHIP_SELECT_HI_OUT(cs_hi), .MEM_WRITE_STROBE_N_OUT(we_n), .MEM_OUTPUT_EN_N_OUT(oe_n),
    .MEM_HIGH_BYTE_SEL_N_OUT(hb_n), .MEM_LOW_BYTE_SEL_N_OUT(lb_n), .MEM_DATA_IN(din),
    .MEM_DATA_OUT(dout), .MEM_DATA_OE_N_OUT(doe_n));
  asc_sram_model mdl (.addr_in(ma), .cs_n_in(cs_n), .cs_hi_in(cs_hi), .we_n_in(we_n),
    .oe_n_in(oe_n), .hb_n_in(hb_n), .lb_n_in(lb_n), .bus_in(din), .host_oe_n_in(doe_n),
    .rdata_out(mq), .fault_out(flt));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One request; for reads d is the expected word
  task automatic op(input logic w, input logic [19:0] a, input logic [15:0] d, input logic [1:0] be);
    int n_we, n_rsp, k;
    logic [15:0] q, m;
    n_we = 0;
    n_rsp = 0;
    k = 0;
    q = 16'h0000;
    m = {{8{be[1]}}, {8{be[0]}}};
    while (rdy !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    rv = 1'b1;
    rw = w;
    ra = a;
    rd_d = d;
    rbe = be;
    @(posedge clk);
    #1;
    rv = 1'b0;
    do begin
      @(posedge clk);
      #1;
      k++;
      if (rsv === 1'b1) begin
        n_rsp++;
        q = rsd;
      end
      if (cs_n === 1'b0) chk("pin address", ma, a);
      if (we_n === 1'b0) begin
        n_we++;
        chk("write pins", {cs_n, cs_hi, oe_n, hb_n, lb_n, doe_n, dout}, {3'b011, ~be, 1'b0, d});
      end
      if (oe_n === 1'b0) chk("read pins", {cs_n, cs_hi, we_n, hb_n, lb_n, doe_n}, {3'b011, ~be, 1'b1});
    end while (rdy !== 1'b1 && k < 20);
    chk("response count", n_rsp, {31'h0, !w});
    chk("strobe cycles", n_we, w ? WR_CYC : 0);
    if (!w) chk("read data", q & m, d & m);
  endtask
  task automatic t_reset();
    repeat (10) @(posedge clk);
    #1;
    chk("reset pins", {rdy, rsv, cs_n, cs_hi, we_n, oe_n, hb_n, lb_n, doe_n}, 9'h05F);
    rst = 1'b0;
    @(posedge clk);
    #1;
    chk("ready after reset", rdy, 1'b1);
  endtask
  task automatic t_words();
    op(1'b1, 20'h00000, 16'hA55A, 2'b11);
    op(1'b1, 20'hFFFFF, 16'h3CC3, 2'b11);
    op(1'b0, 20'h00000, 16'hA55A, 2'b11);
    op(1'b0, 20'hFFFFF, 16'h3CC3, 2'b11);
  endtask
  task automatic t_lanes();
    op(1'b1, 20'h12345, 16'h1111, 2'b11);
    op(1'b1, 20'h12345, 16'h22AB, 2'b01);
    op(1'b1, 20'h12345, 16'hCD33, 2'b10);
    op(1'b0, 20'h12345, 16'hCDAB, 2'b11);
    op(1'b0, 20'h12345, 16'h00AB, 2'b01);
    op(1'b0, 20'h12345, 16'hCD00, 2'b10);
  endtask
  task automatic t_refuse();
    rv = 1'b1;
    rw = 1'b1;
    rbe = 2'b00;
    repeat (5) begin
      @(posedge clk);
      #1;
      chk("idle pins", {rdy, cs_n, we_n, doe_n}, 4'hF);
    end
    rv = 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #(CLK_PERIOD_NS * 3000);
    n_errors++;
    finish_test();
  end
  initial begin
    rst = 1'b1;
    rv = 1'b0;
    rw = 1'b0;
    ra = 20'h00000;
    rd_d = 16'h0000;
    rbe = 2'b00;
    t_reset();
    t_words();
    t_lanes();
    t_refuse();
    op(1'b0, 20'h00000, 16'hA55A, 2'b11);
    chk("model fault", flt, 1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
